// >>> inc/info_resp_pkg.sv
package info_resp_pkg;
    // =========================================================
    // response type byte layout
    localparam logic [2:0] TYPE_INFO = 3'b010;
    localparam int RDO_BIT = 7;
    localparam logic [2:0] TYPE_NONE = 3'b000;

    // =========================================================
    // return key / slot byte layout
    localparam int KEY_FIELD_W = 5;
    localparam int KEY_READ_BIT = 5;
    localparam int KEY_RDCLR_BIT = 6;
    localparam int KEY_SPARE_BIT = 7;
    localparam logic [4:0] KEY_MODEM = 5'h08;
    localparam logic [4:0] KEY_BUFRET = 5'h10;

    // =========================================================
    // request kinds offered on the request port
    localparam logic [2:0] KIND_READ = 3'h0;
    localparam logic [2:0] KIND_RDCLR = 3'h1;
    localparam logic [2:0] KIND_MODEM = 3'h2;
    localparam logic [2:0] KIND_START = 3'h3;
    localparam logic [2:0] KIND_MAINT = 3'h4;
    localparam logic [2:0] KIND_HALT = 3'h5;

    // =========================================================
    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// >>> verilog/status_slot_ram.sv
`timescale 1ns/1ps
// =========================================================
// status slot store, one write port, registered read
module status_slot_ram #(
    parameter int AW = 9,
    parameter int DW = 16
) (
    input wire logic clk_i, // clock
    input wire logic reset_i, // async reset, active high
    input wire logic ce_i, // clock enable
    input wire logic rd_en_i, // read strobe
    input wire logic [AW-1:0] rd_addr_i, // read address
    output logic [DW-1:0] rd_data_o, // read data, registered
    input wire logic wr_en_i, // write strobe
    input wire logic [AW-1:0] wr_addr_i, // write address
    input wire logic [DW-1:0] wr_data_i // write data
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rd_data_q;

    always_ff @(posedge clk_i)
    begin
        if (ce_i && wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // read before write: a same-cycle clear returns the old contents
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_data_q <= '0;
        end
        else if (ce_i && rd_en_i)
        begin
            rd_data_q <= mem_q[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_q;
endmodule // status_slot_ram

// >>> verilog/info_response_formatter.sv
`timescale 1ns/1ps
// Summary of operation
// - information response type code is 010
// - tributary address and requested data word
// - global slot data gives zero station address
// - key bits 0-4 hold key or slot
// - slot low byte first, high byte second
// - slot access answered only by information response
// - plain read sets key bit 5
// - read-and-clear sets bit 6, clears slot; a host slot write in the same cycle cancels the clear
// - key octal 10 means modem status
// - key octal 20 after all buffers returned
// - buffer return complete has zero data
// - start while running returns tributary buffers
// - maintenance while running returns tributary buffers
// - halt request returns tributary buffers
// - global halt returns unused pool buffers
// - load data first, then ready-out and type
module info_response_formatter #(
    parameter int TRIB_AW = 3,
    parameter int SLOT_AW = 5
) (
    input wire logic CLK_I, // 20 MHz clock
    input wire logic RESET_I, // async reset, active high
    input wire logic CE_I, // clock enable, freezes all state when low
    input wire logic REQ_VALID_I, // request strobe
    input wire logic [2:0] REQ_KIND_I, // request kind
    input wire logic REQ_GLOBAL_I, // request targets global slots / pool
    input wire logic [7:0] REQ_TRIB_I, // tributary address
    input wire logic [4:0] REQ_SLOT_I, // status slot address
    input wire logic [7:0] REQ_COUNT_I, // buffers due for return
    input wire logic [15:0] MODEM_STATUS_I, // current modem status
    input wire logic SLOT_WR_I, // status slot write strobe
    input wire logic SLOT_WR_GLOBAL_I, // write targets global slot
    input wire logic [7:0] SLOT_WR_TRIB_I, // write tributary address
    input wire logic [4:0] SLOT_WR_ADDR_I, // write slot address
    input wire logic [15:0] SLOT_WR_DATA_I, // write data
    input wire logic RDO_CLR_I, // host clears ready-out flag
    output logic REQ_READY_O, // request may be taken
    output logic [7:0] RESPONSE_TYPE_BYTE_O, // ready-out flag and type code
    output logic READY_OUT_FLAG_O, // response waiting for host
    output logic [7:0] STATION_ADDRESS_BYTE_O, // station address
    output logic [7:0] RESPONSE_DATA_LOW_BYTE_O, // data low byte
    output logic [7:0] RESPONSE_DATA_HIGH_BYTE_O, // data high byte
    output logic [7:0] RETURN_KEY_SLOT_BYTE_O, // return key / slot byte
    output logic BUF_RET_O, // one buffer returned, pulse
    output logic [7:0] BUF_RET_TRIB_O, // tributary of returned buffer
    output logic BUF_RET_POOL_O // returned buffer is a common pool one
);
    localparam int RAM_AW = 1 + TRIB_AW + SLOT_AW;
    // width of the key / slot field in the key byte
    localparam int KW = info_resp_pkg::KEY_FIELD_W;

    // =========================================================
    // state
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_RETURN, ST_LOAD, ST_POST} state_t;

    typedef struct packed {
        state_t st;
        logic rdy;
        logic ready_out_flag;
        logic [2:0] rtype;
        logic [7:0] addr;
        logic [7:0] dlo;
        logic [7:0] dhi;
        logic [7:0] key;
        logic [2:0] kind;
        logic glob;
        logic [7:0] trib;
        logic [4:0] slot;
        logic [7:0] cnt;
        logic [15:0] mdat;
        logic bret;
        logic pool;
    } regs_t;

    regs_t q;
    regs_t d;

    logic [15:0] ram_rdata;
    logic ram_rd_en;
    logic [RAM_AW-1:0] ram_rd_addr;
    logic ram_wr_en;
    logic [RAM_AW-1:0] ram_wr_addr;
    logic [15:0] ram_wr_data;
    logic clr_en;

    function automatic logic [RAM_AW-1:0] slot_addr(input logic glob, input logic [7:0] trib,
                                                    input logic [4:0] slot);
        logic [TRIB_AW-1:0] t;
        t = glob ? '0 : trib[TRIB_AW-1:0];
        slot_addr = {glob, t, slot[SLOT_AW-1:0]};
    endfunction

    function automatic logic is_bufret(input logic [2:0] kind);
        is_bufret = (kind == info_resp_pkg::KIND_START) || (kind == info_resp_pkg::KIND_MAINT)
            || (kind == info_resp_pkg::KIND_HALT);
    endfunction

    // =========================================================
    // status slot store
    assign ram_rd_en = (q.st == ST_FETCH);
    assign ram_rd_addr = slot_addr(q.glob, q.trib, q.slot);
    assign clr_en = (q.st == ST_LOAD) && (q.kind == info_resp_pkg::KIND_RDCLR);
    // host write wins over the clear so a write in the clear cycle is never lost
    assign ram_wr_en = SLOT_WR_I || clr_en;
    assign ram_wr_addr = SLOT_WR_I ? slot_addr(SLOT_WR_GLOBAL_I, SLOT_WR_TRIB_I, SLOT_WR_ADDR_I)
                                   : ram_rd_addr;
    assign ram_wr_data = SLOT_WR_I ? SLOT_WR_DATA_I : info_resp_pkg::WORD_RESET;

    status_slot_ram #(
        .AW(RAM_AW),
        .DW(16)
    ) u_slots (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .ce_i(CE_I),
        .rd_en_i(ram_rd_en),
        .rd_addr_i(ram_rd_addr),
        .rd_data_o(ram_rdata),
        .wr_en_i(ram_wr_en),
        .wr_addr_i(ram_wr_addr),
        .wr_data_i(ram_wr_data)
    );

    // =========================================================
    // next state
    always_comb
    begin
        d = q;
        d.bret = 1'b0;
        // clear applied first so a post in the same cycle still raises the flag
        if (RDO_CLR_I)
        begin
            d.ready_out_flag = 1'b0;
        end
        unique case (q.st)
            ST_IDLE:
            begin
                if (REQ_VALID_I && q.rdy)
                begin
                    d.kind = REQ_KIND_I;
                    d.glob = REQ_GLOBAL_I;
                    d.trib = REQ_TRIB_I;
                    d.slot = REQ_SLOT_I;
                    d.cnt = REQ_COUNT_I;
                    d.mdat = MODEM_STATUS_I;
                    d.pool = REQ_GLOBAL_I && (REQ_KIND_I == info_resp_pkg::KIND_HALT);
                    if ((REQ_KIND_I == info_resp_pkg::KIND_READ)
                        || (REQ_KIND_I == info_resp_pkg::KIND_RDCLR))
                    begin
                        d.st = ST_FETCH;
                    end
                    else if (is_bufret(REQ_KIND_I) && (REQ_COUNT_I != 8'h00))
                    begin
                        d.st = ST_RETURN;
                    end
                    else
                    begin
                        d.st = ST_LOAD;
                    end
                end
            end
            ST_FETCH:
            begin
                d.st = ST_LOAD;
            end
            ST_RETURN:
            begin
                d.bret = 1'b1;
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01)
                begin
                    d.st = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                d.addr = q.glob ? info_resp_pkg::BYTE_RESET : q.trib;
                d.key = info_resp_pkg::BYTE_RESET;
                if (is_bufret(q.kind))
                begin
                    d.dlo = info_resp_pkg::BYTE_RESET;
                    d.dhi = info_resp_pkg::BYTE_RESET;
                    d.key[KW-1:0] = info_resp_pkg::KEY_BUFRET;
                end
                else if (q.kind == info_resp_pkg::KIND_MODEM)
                begin
                    d.dlo = q.mdat[7:0];
                    d.dhi = q.mdat[15:8];
                    d.key[KW-1:0] = info_resp_pkg::KEY_MODEM;
                end
                else
                begin
                    d.dlo = ram_rdata[7:0];
                    d.dhi = ram_rdata[15:8];
                    d.key[KW-1:0] = q.slot;
                    d.key[info_resp_pkg::KEY_READ_BIT] =
                        (q.kind == info_resp_pkg::KIND_READ);
                    d.key[info_resp_pkg::KEY_RDCLR_BIT] =
                        (q.kind == info_resp_pkg::KIND_RDCLR);
                end
                d.st = ST_POST;
            end
            ST_POST:
            begin
                // flag raised a cycle after the data bytes settle
                d.ready_out_flag = 1'b1;
                d.rtype = info_resp_pkg::TYPE_INFO;
                d.st = ST_IDLE;
            end
        endcase
        d.rdy = (d.st == ST_IDLE) && !d.ready_out_flag;
    end

    // =========================================================
    // registers
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            q <= '{st: ST_IDLE, rdy: 1'b1, ready_out_flag: 1'b0, rtype: info_resp_pkg::TYPE_NONE,
                   addr: info_resp_pkg::BYTE_RESET, dlo: info_resp_pkg::BYTE_RESET,
                   dhi: info_resp_pkg::BYTE_RESET, key: info_resp_pkg::BYTE_RESET,
                   kind: info_resp_pkg::KIND_READ, glob: 1'b0,
                   trib: info_resp_pkg::BYTE_RESET, slot: 5'h00,
                   cnt: info_resp_pkg::BYTE_RESET, mdat: info_resp_pkg::WORD_RESET,
                   bret: 1'b0, pool: 1'b0};
        end
        else if (CE_I)
        begin
            q <= d;
        end
    end

    // =========================================================
    // outputs
    assign REQ_READY_O = q.rdy;
    assign READY_OUT_FLAG_O = q.ready_out_flag;
    assign RESPONSE_TYPE_BYTE_O = {q.ready_out_flag, 4'h0, q.rtype};
    assign STATION_ADDRESS_BYTE_O = q.addr;
    assign RESPONSE_DATA_LOW_BYTE_O = q.dlo;
    assign RESPONSE_DATA_HIGH_BYTE_O = q.dhi;
    assign RETURN_KEY_SLOT_BYTE_O = q.key;
    assign BUF_RET_O = q.bret;
    assign BUF_RET_TRIB_O = q.trib;
    assign BUF_RET_POOL_O = q.pool;

    // =========================================================
    // checks
    a_type_on_rdo: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        $rose(q.ready_out_flag) |-> (q.rtype == info_resp_pkg::TYPE_INFO))
        else $error("ready-out raised without information type code");

    a_trib_addr: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_LOAD && !q.glob) |=> (q.addr == $past(q.trib)))
        else $error("station address not the tributary address");

    a_global_zero: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_LOAD && q.glob) |=> (q.addr == 8'h00))
        else $error("global response has nonzero station address");

    a_byte_order: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_LOAD && q.kind == info_resp_pkg::KIND_READ)
        |=> (q.dlo == $past(ram_rdata[7:0])) && (q.dhi == $past(ram_rdata[15:8])))
        else $error("slot data bytes swapped or stale");

    a_read_key: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_LOAD && q.kind == info_resp_pkg::KIND_READ)
        |=> (q.key == {3'b001, $past(q.slot)}))
        else $error("read response key byte wrong");

    a_rdclr_key: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_LOAD && q.kind == info_resp_pkg::KIND_RDCLR)
        |-> ram_wr_en ##1 (q.key == {3'b010, $past(q.slot)}))
        else $error("read-and-clear key wrong or slot not cleared");

    a_modem_key: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_LOAD && q.kind == info_resp_pkg::KIND_MODEM)
        |=> (q.key == 8'h08) && ({q.dhi, q.dlo} == $past(q.mdat)))
        else $error("modem status response wrong");

    a_bufret_zero: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (q.ready_out_flag && q.key == 8'h10) |-> (q.dlo == 8'h00) && (q.dhi == 8'h00))
        else $error("buffer return complete carries data");

    a_return_done: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_RETURN && q.cnt == 8'h01) |=> q.bret && (q.st == ST_LOAD))
        else $error("last buffer not followed by completion load");

    // bytes are loaded one edge ahead, so the flag must still be low at post
    a_load_then_rdo: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        (CE_I && q.st == ST_POST) |-> !q.ready_out_flag ##1 (q.ready_out_flag && $stable(q.key)))
        else $error("ready-out not raised after data load");

    a_key_bit7: assert property (
        @(posedge CLK_I) disable iff (RESET_I)
        q.ready_out_flag |-> !q.key[info_resp_pkg::KEY_SPARE_BIT])
        else $error("key byte bit 7 set");
endmodule // info_response_formatter

// >>> dv/info_response_formatter_tb.sv
`timescale 1ns/1ps
module info_response_formatter_tb;
    // =========================================================
    // stimulus and observed signals
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic CE_I = 1'b1;
    logic REQ_VALID_I = 1'b0;
    logic [2:0] REQ_KIND_I = 3'h0;
    logic REQ_GLOBAL_I = 1'b0;
    logic [7:0] REQ_TRIB_I = 8'h00;
    logic [4:0] REQ_SLOT_I = 5'h00;
    logic [7:0] REQ_COUNT_I = 8'h00;
    logic [15:0] MODEM_STATUS_I = 16'h0000;
    logic SLOT_WR_I = 1'b0;
    logic SLOT_WR_GLOBAL_I = 1'b0;
    logic [7:0] SLOT_WR_TRIB_I = 8'h00;
    logic [4:0] SLOT_WR_ADDR_I = 5'h00;
    logic [15:0] SLOT_WR_DATA_I = 16'h0000;
    logic RDO_CLR_I = 1'b0;
    logic REQ_READY_O, READY_OUT_FLAG_O, BUF_RET_O, BUF_RET_POOL_O;
    logic [7:0] RESPONSE_TYPE_BYTE_O, STATION_ADDRESS_BYTE_O, RETURN_KEY_SLOT_BYTE_O;
    logic [7:0] RESPONSE_DATA_LOW_BYTE_O, RESPONSE_DATA_HIGH_BYTE_O, BUF_RET_TRIB_O;
    int error_cnt = 0;
    int num_checks = 0;
    int pulses;
    logic [7:0] pulse_trib;
    logic pulse_pool;
    logic [31:0] pre_bytes;

    always #25 CLK_I = ~CLK_I;

    info_response_formatter dut (
        .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I),
        .REQ_VALID_I(REQ_VALID_I), .REQ_KIND_I(REQ_KIND_I), .REQ_GLOBAL_I(REQ_GLOBAL_I),
        .REQ_TRIB_I(REQ_TRIB_I), .REQ_SLOT_I(REQ_SLOT_I), .REQ_COUNT_I(REQ_COUNT_I),
        .MODEM_STATUS_I(MODEM_STATUS_I), .SLOT_WR_I(SLOT_WR_I),
        .SLOT_WR_GLOBAL_I(SLOT_WR_GLOBAL_I), .SLOT_WR_TRIB_I(SLOT_WR_TRIB_I),
        .SLOT_WR_ADDR_I(SLOT_WR_ADDR_I), .SLOT_WR_DATA_I(SLOT_WR_DATA_I),
        .RDO_CLR_I(RDO_CLR_I), .REQ_READY_O(REQ_READY_O),
        .RESPONSE_TYPE_BYTE_O(RESPONSE_TYPE_BYTE_O), .READY_OUT_FLAG_O(READY_OUT_FLAG_O),
        .STATION_ADDRESS_BYTE_O(STATION_ADDRESS_BYTE_O),
        .RESPONSE_DATA_LOW_BYTE_O(RESPONSE_DATA_LOW_BYTE_O),
        .RESPONSE_DATA_HIGH_BYTE_O(RESPONSE_DATA_HIGH_BYTE_O),
        .RETURN_KEY_SLOT_BYTE_O(RETURN_KEY_SLOT_BYTE_O), .BUF_RET_O(BUF_RET_O),
        .BUF_RET_TRIB_O(BUF_RET_TRIB_O), .BUF_RET_POOL_O(BUF_RET_POOL_O)
    );

    // =========================================================
    // checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // =========================================================
    // access tasks, all driven at the falling edge
    task automatic slot_write(input logic glob, input logic [7:0] trib, input logic [4:0] addr,
                              input logic [15:0] data);
        @(negedge CLK_I);
        SLOT_WR_I = 1'b1;
        SLOT_WR_GLOBAL_I = glob;
        SLOT_WR_TRIB_I = trib;
        SLOT_WR_ADDR_I = addr;
        SLOT_WR_DATA_I = data;
        @(negedge CLK_I);
        SLOT_WR_I = 1'b0;
    endtask

    // issue one request, wait for ready-out and compare the response bytes
    task automatic request(input logic [2:0] kind, input logic glob, input logic [7:0] trib,
                           input logic [4:0] slot, input logic [7:0] cnt,
                           input logic [7:0] e_addr, input logic [15:0] e_data,
                           input logic [7:0] e_key);
        int n;
        n = 0;
        while (REQ_READY_O !== 1'b1 && n < 50)
        begin
            @(negedge CLK_I);
            n++;
        end
        check("req_ready", {31'h0, REQ_READY_O}, 32'h1);
        REQ_VALID_I = 1'b1;
        REQ_KIND_I = kind;
        REQ_GLOBAL_I = glob;
        REQ_TRIB_I = trib;
        REQ_SLOT_I = slot;
        REQ_COUNT_I = cnt;
        pulses = 0;
        pulse_trib = 8'h00;
        pulse_pool = 1'b0;
        pre_bytes = 32'h0;
        @(negedge CLK_I);
        REQ_VALID_I = 1'b0;
        n = 0;
        while (READY_OUT_FLAG_O !== 1'b1 && n < 300)
        begin
            if (BUF_RET_O === 1'b1)
            begin
                pulses++;
                pulse_trib = BUF_RET_TRIB_O;
                pulse_pool = BUF_RET_POOL_O;
            end
            pre_bytes = {STATION_ADDRESS_BYTE_O, RESPONSE_DATA_LOW_BYTE_O,
                         RESPONSE_DATA_HIGH_BYTE_O, RETURN_KEY_SLOT_BYTE_O};
            @(negedge CLK_I);
            n++;
        end
        check("ready_out", {31'h0, READY_OUT_FLAG_O}, 32'h1);
        check("type_byte", {24'h0, RESPONSE_TYPE_BYTE_O}, 32'h82);
        check("station", {24'h0, STATION_ADDRESS_BYTE_O}, {24'h0, e_addr});
        check("data_low", {24'h0, RESPONSE_DATA_LOW_BYTE_O}, {24'h0, e_data[7:0]});
        check("data_high", {24'h0, RESPONSE_DATA_HIGH_BYTE_O}, {24'h0, e_data[15:8]});
        check("key_byte", {24'h0, RETURN_KEY_SLOT_BYTE_O}, {24'h0, e_key});
        // bytes must already stand one cycle before ready-out rises
        check("loaded_early", pre_bytes, {STATION_ADDRESS_BYTE_O, RESPONSE_DATA_LOW_BYTE_O,
              RESPONSE_DATA_HIGH_BYTE_O, RETURN_KEY_SLOT_BYTE_O});
    endtask

    task automatic clear_rdo();
        RDO_CLR_I = 1'b1;
        @(negedge CLK_I);
        RDO_CLR_I = 1'b0;
        check("rdo_cleared", {31'h0, READY_OUT_FLAG_O}, 32'h0);
        check("ready_back", {31'h0, REQ_READY_O}, 32'h1);
    endtask

    // =========================================================
    // test sequence
    logic [2:0] ret_kind [3] = '{info_resp_pkg::KIND_START, info_resp_pkg::KIND_MAINT,
                                 info_resp_pkg::KIND_HALT};
    logic [7:0] ret_cnt [3] = '{8'h02, 8'h00, 8'h03};

    initial
    begin
        repeat (8) @(posedge CLK_I);
        @(negedge CLK_I);
        check("reset_ready", {31'h0, REQ_READY_O}, 32'h1);
        check("reset_type", {24'h0, RESPONSE_TYPE_BYTE_O}, 32'h0);
        RESET_I = 1'b0;
        slot_write(1'b0, 8'h03, 5'h05, 16'hBEEF);
        slot_write(1'b1, 8'h00, 5'h02, 16'h1234);
        request(info_resp_pkg::KIND_READ, 1'b0, 8'h03, 5'h05, 8'h00, 8'h03, 16'hBEEF,
                8'h25);
        clear_rdo();
        request(info_resp_pkg::KIND_RDCLR, 1'b0, 8'h03, 5'h05, 8'h00, 8'h03, 16'hBEEF,
                8'h45);
        clear_rdo();
        // the slot must now read back as cleared
        request(info_resp_pkg::KIND_READ, 1'b0, 8'h03, 5'h05, 8'h00, 8'h03, 16'h0000,
                8'h25);
        clear_rdo();
        request(info_resp_pkg::KIND_READ, 1'b1, 8'h03, 5'h02, 8'h00, 8'h00, 16'h1234,
                8'h22);
        clear_rdo();
        MODEM_STATUS_I = 16'hA55A;
        request(info_resp_pkg::KIND_MODEM, 1'b1, 8'h00, 5'h00, 8'h00, 8'h00, 16'hA55A,
                8'h08);
        MODEM_STATUS_I = 16'h0F0F;
        clear_rdo();
        for (int i = 0; i < 3; i++)
        begin
            request(ret_kind[i], 1'b0, 8'h04, 5'h00, ret_cnt[i], 8'h04, 16'h0000,
                    8'h10);
            check("ret_count", pulses, {24'h0, ret_cnt[i]});
            if (ret_cnt[i] != 8'h00)
                check("ret_trib", {24'h0, pulse_trib}, 32'h04);
            check("ret_pool", {31'h0, pulse_pool}, 32'h0);
            clear_rdo();
        end
        request(info_resp_pkg::KIND_HALT, 1'b1, 8'h00, 5'h00, 8'h04, 8'h00, 16'h0000,
                8'h10);
        check("pool_count", pulses, 32'h4);
        check("pool_flag", {31'h0, pulse_pool}, 32'h1);
        // with the clock enable low a host clear must not take effect
        CE_I = 1'b0;
        RDO_CLR_I = 1'b1;
        @(negedge CLK_I);
        RDO_CLR_I = 1'b0;
        CE_I = 1'b1;
        check("ce_frozen", {31'h0, READY_OUT_FLAG_O}, 32'h1);
        // a request offered while ready-out is pending must leave no trace
        REQ_VALID_I = 1'b1;
        REQ_KIND_I = info_resp_pkg::KIND_HALT;
        REQ_COUNT_I = 8'h05;
        @(negedge CLK_I);
        REQ_VALID_I = 1'b0;
        clear_rdo();
        pulses = 0;
        repeat (20)
        begin
            @(negedge CLK_I);
            if (BUF_RET_O !== 1'b0 || READY_OUT_FLAG_O !== 1'b0)
                pulses++;
        end
        check("refused_quiet", pulses, 32'h0);
        // reset in mid-run, then one more response from a clean start
        RESET_I = 1'b1;
        @(negedge CLK_I);
        check("mid_reset_type", {24'h0, RESPONSE_TYPE_BYTE_O}, 32'h0);
        check("mid_reset_key", {24'h0, RETURN_KEY_SLOT_BYTE_O}, 32'h0);
        RESET_I = 1'b0;
        request(info_resp_pkg::KIND_MODEM, 1'b0, 8'h06, 5'h00, 8'h00, 8'h06, 16'h0F0F,
                8'h08);
        report_and_stop();
    end

    // =========================================================
    // watchdog, the whole sequence needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge CLK_I);
        error_cnt++;
        report_and_stop();
    end
endmodule // info_response_formatter_tb
